// ---- logic/pmtb_pkg.sv ----
package pmtb_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_DIVSEL  = 4'h4;
  localparam logic [3:0] OFS_PERIOD  = 4'h8;
  localparam logic [3:0] OFS_IRQ_ST  = 4'hC;

  // ****************************************
  // control field positions
  // ****************************************
  localparam int B_ON       = 15;
  localparam int B_IDLE     = 13;
  localparam int B_SEFLAG   = 12;
  localparam int B_SPECIAL_EVENT_IRQ_ENABLE    = 11;
  localparam int B_IMMUPD   = 10;
  localparam int B_SYNC_POLARITY  = 9;
  localparam int B_SYNC_OUT_ENABLE  = 8;
  localparam int B_EXT_SYNC_ENABLE   = 7;
  localparam int B_SRC_LO   = 4;
  localparam int B_PS_LO    = 0;
  localparam logic [15:0] CTRL_WMASK = 16'hAFBF;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [2:0]  DIV_RST    = 3'h0;
  localparam logic [15:0] PERIOD_RST = 16'hFFF8;
  localparam logic [1:0]  IRQ_RST    = 2'h0;

  // ****************************************
  // divider codes
  // ****************************************
  localparam logic [2:0] DIV_MAX_CODE = 3'h6;
  localparam int         PRE_W        = 6;

  // ****************************************
  // bus responses
  // ****************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PMTB_IDLE = 2'b00,
    PMTB_RUN  = 2'b01,
    PMTB_HALT = 2'b10
  } pmtb_state_e;

endpackage

// ---- logic/pmtb_prescaler.sv ----
`timescale 1ns/1ps
module pmtb_prescaler
  import pmtb_pkg::*;
#(
  parameter int W = PRE_W
) (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // control
  input  wire logic       run_i,
  input  wire logic [2:0] sel_i,
  // output
  output logic            tick_o
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic [W-1:0] lim;

  // ****************************************
  // ratio decode
  // ****************************************
  // 000 divides by one; 111 is reserved and treated as the largest ratio
  assign lim = (sel_i > DIV_MAX_CODE) ? {W{1'b1}} :
               W'((32'h1 << sel_i) - 32'h1);
  assign tick_o  = run_i && (cnt_ff >= lim);
  assign nxt_cnt = (!run_i || tick_o) ? '0 : cnt_ff + W'(1);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
    end else if (ce_i) begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

// ---- logic/pmtb_top.sv ----
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module pmtb_top
  import pmtb_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // device idle request
  input  wire logic        idle_mode_i,
  // external sync pins
  input  wire logic        sync_input1_i,
  input  wire logic        sync_input2_i,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [3:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [3:0]  s_axi_araddr,
  // axi4-lite read data
  input  wire logic        s_axi_rvalid_unused_i,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // time base outputs
  output logic [15:0]      count_o,
  output logic             sync_output_o,
  output logic             special_event_o,
  output logic             irq_o
);

  // ****************************************
  // registers
  // ****************************************
  logic [15:0] ctrl_ff;
  logic [2:0]  div_ff;
  logic [15:0] per_ff;
  logic [15:0] per_act_ff;
  logic [1:0]  irq_st_ff;
  logic [1:0]  irq_mask_ff;
  logic [15:0] cnt_ff;
  logic [3:0]  post_ff;
  pmtb_state_e state_ff;
  logic [2:0]  s1_ff;
  logic [2:0]  s2_ff;
  logic        sync_o_ff;
  logic        sev_ff;
  logic        aw_ff;
  logic        w_ff;
  logic [3:0]  awa_ff;
  logic [31:0] wd_ff;
  logic [3:0]  ws_ff;
  logic        bv_ff;
  logic [1:0]  br_ff;
  logic        rv_ff;
  logic [31:0] rd_ff;
  logic [1:0]  rr_ff;

  // ****************************************
  // control field decode
  // ****************************************
  wire       on       = ctrl_ff[B_ON];
  wire       idle_hlt = ctrl_ff[B_IDLE] && idle_mode_i;
  wire       imm_upd  = ctrl_ff[B_IMMUPD];
  wire       spol     = ctrl_ff[B_SYNC_POLARITY];
  wire       sync_en  = ctrl_ff[B_EXT_SYNC_ENABLE];
  wire [1:0] src      = ctrl_ff[B_SRC_LO +: 2];
  wire [3:0] post_lim = ctrl_ff[B_PS_LO +: 4];

  // ****************************************
  // sync input synchronisers
  // ****************************************
  // stage 0 is metastable; edges are judged only on stages 1 and 2
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s1_ff <= 3'h0;
      s2_ff <= 3'h0;
    end else if (ce_i) begin
      s1_ff <= {s1_ff[1:0], sync_input1_i};
      s2_ff <= {s2_ff[1:0], sync_input2_i};
    end
  end

  wire [1:0] sync_pair = (src == 2'h1) ? s2_ff[2:1] : s1_ff[2:1];
  wire [1:0] sync_lvl  = spol ? ~sync_pair : sync_pair;
  // reserved sources give no sync; period must exceed sync period
  wire ext_sync = sync_en && !src[1] && sync_lvl[0] && !sync_lvl[1];

  // ****************************************
  // time base
  // ****************************************
  logic tick;
  wire  run = (state_ff == PMTB_RUN);

  pmtb_prescaler #(
    .W (PRE_W)
  ) u_pre (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .run_i     (run),
    .sel_i     (div_ff),
    .tick_o    (tick)
  );

  wire period_end = tick && (cnt_ff >= per_act_ff);
  wire restart    = period_end || (run && ext_sync);
  wire post_hit   = restart && (post_ff == post_lim);

  pmtb_state_e nxt_state;
  always_comb begin
    case (state_ff)
      PMTB_IDLE: nxt_state = on ? PMTB_RUN : PMTB_IDLE;
      PMTB_RUN: begin
        if (!on) nxt_state = PMTB_IDLE;
        else if (idle_hlt) nxt_state = PMTB_HALT;
        else nxt_state = PMTB_RUN;
      end
      PMTB_HALT: begin
        if (!on) nxt_state = PMTB_IDLE;
        else if (!idle_hlt) nxt_state = PMTB_RUN;
        else nxt_state = PMTB_HALT;
      end
      default: nxt_state = PMTB_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_ff   <= PMTB_IDLE;
      cnt_ff     <= 16'h0000;
      post_ff    <= 4'h0;
      per_act_ff <= PERIOD_RST;
      sync_o_ff  <= 1'b0;
      sev_ff     <= 1'b0;
    end else if (ce_i) begin
      state_ff  <= nxt_state;
      sync_o_ff <= restart && ctrl_ff[B_SYNC_OUT_ENABLE];
      sev_ff    <= post_hit;
      if (state_ff == PMTB_IDLE) begin
        cnt_ff  <= 16'h0000;
        post_ff <= 4'h0;
      end else if (restart) begin
        cnt_ff  <= 16'h0000;
        post_ff <= post_hit ? 4'h0 : post_ff + 4'h1;
      end else if (tick) begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
      // shadow period: at boundary, every cycle in PMTB_IDLE, or at once when immediate update
      if (imm_upd || restart || state_ff == PMTB_IDLE) begin
        per_act_ff <= per_ff;
      end
    end
  end

  assign count_o         = cnt_ff;
  assign sync_output_o   = spol ? !sync_o_ff : sync_o_ff;
  assign special_event_o = sev_ff;

  // ****************************************
  // axi4-lite slave
  // ****************************************
  wire do_wr = aw_ff && w_ff && !bv_ff;
  wire do_rd = s_axi_arvalid && !rv_ff;
  assign s_axi_awready = !aw_ff && !bv_ff;
  assign s_axi_wready  = !w_ff && !bv_ff;
  assign s_axi_arready = !rv_ff;
  assign s_axi_bvalid  = bv_ff;
  assign s_axi_bresp   = br_ff;
  assign s_axi_rvalid  = rv_ff;
  assign s_axi_rdata   = rd_ff;
  assign s_axi_rresp   = rr_ff;

  wire wr_ctrl = do_wr && awa_ff == OFS_CONTROL;
  wire wr_div  = do_wr && awa_ff == OFS_DIVSEL;
  wire wr_per  = do_wr && awa_ff == OFS_PERIOD;
  wire wr_irq  = do_wr && awa_ff == OFS_IRQ_ST;
  wire wr_hit  = wr_ctrl || wr_div || wr_per || wr_irq;
  wire rd_st   = do_rd && s_axi_araddr == OFS_IRQ_ST;
  wire [15:0] wmsk = {{8{ws_ff[1]}}, {8{ws_ff[0]}}};

  // status byte: [1] special event, [0] period end; mask in bits 9:8
  wire [31:0] rd_mux =
    (s_axi_araddr == OFS_CONTROL) ? {16'h0000, ctrl_ff} :
    (s_axi_araddr == OFS_DIVSEL)  ? {29'h0, div_ff} :
    (s_axi_araddr == OFS_PERIOD)  ? {16'h0000, per_ff} :
    {22'h0, irq_mask_ff, 6'h0, irq_st_ff};
  wire rd_ok = (s_axi_araddr == OFS_CONTROL) ||
               (s_axi_araddr == OFS_DIVSEL) ||
               (s_axi_araddr == OFS_PERIOD) || rd_st;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      aw_ff <= 1'b0;
      w_ff  <= 1'b0;
      awa_ff <= 4'h0;
      wd_ff <= 32'h0000_0000;
      ws_ff <= 4'h0;
      bv_ff <= 1'b0;
      br_ff <= RESP_OKAY;
      rv_ff <= 1'b0;
      rd_ff <= 32'h0000_0000;
      rr_ff <= RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff  <= 1'b1;
        // unaligned addresses match no register and get an error
        awa_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff  <= 1'b1;
        wd_ff <= s_axi_wdata;
        ws_ff <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_ff <= 1'b0;
        w_ff  <= 1'b0;
        bv_ff <= 1'b1;
        br_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bv_ff && s_axi_bready) begin
        bv_ff <= 1'b0;
      end
      if (do_rd) begin
        rv_ff <= 1'b1;
        rd_ff <= rd_mux;
        rr_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rv_ff && s_axi_rready) begin
        rv_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // register file and interrupts
  // ****************************************
  // flag set wins over a clearing read in the same cycle
  wire [1:0] ev = {post_hit, period_end};
  wire [15:0] ctrl_wr = (ctrl_ff & ~wmsk) | (wd_ff[15:0] & wmsk);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl_ff     <= CTRL_RST;
      div_ff      <= DIV_RST;
      per_ff      <= PERIOD_RST;
      irq_st_ff   <= IRQ_RST;
      irq_mask_ff <= IRQ_RST;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        // rely on software; fields are not locked here
        ctrl_ff <= (ctrl_wr & CTRL_WMASK) |
                   (16'h0001 << B_SEFLAG) & {16{post_hit ||
                   (ctrl_ff[B_SEFLAG] && wd_ff[B_SEFLAG])}};
      end else if (post_hit) begin
        ctrl_ff[B_SEFLAG] <= 1'b1;
      end
      if (wr_div && ws_ff[0]) begin
        div_ff <= wd_ff[2:0];
      end
      if (wr_per) begin
        per_ff <= (per_ff & ~wmsk) | (wd_ff[15:0] & wmsk);
      end
      if (wr_irq && ws_ff[1]) begin
        irq_mask_ff <= wd_ff[9:8];
      end
      irq_st_ff <= (rd_st ? 2'h0 : irq_st_ff) | ev;
    end
  end

  assign irq_o = |(irq_st_ff & irq_mask_ff) ||
                 (ctrl_ff[B_SEFLAG] && ctrl_ff[B_SPECIAL_EVENT_IRQ_ENABLE]);

endmodule

// ---- tb/pmtb_assertions.sv ----
`timescale 1ns/1ps
module pmtb_assertions (
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [15:0] count_o,
  input wire logic        special_event_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // ****************************************
  // checks
  // ****************************************
  // restart or sync may only take the count back to zero
  property p_cnt_step;
    $changed(count_o) |-> count_o == $past(count_o) + 16'h1
      || count_o == 16'h0;
  endproperty
  a_cnt_step: assert property (p_cnt_step)
    else $error("count skipped a value");
  property p_rst_val;
    $fell(rst_i) |-> count_o == 16'h0 && !s_axi_rvalid;
  endproperty
  a_rst_val: assert property (p_rst_val)
    else $error("state not cleared by reset");
  property p_sev_pulse;
    special_event_o |=> !special_event_o;
  endproperty
  a_sev_pulse: assert property (p_sev_pulse)
    else $error("special event longer than one cycle");
  property p_r_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_ans: assert property (p_r_ans)
    else $error("read answer late");
  property p_b_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_once: assert property (p_b_once)
    else $error("write response repeated");
  property p_r_once;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_once: assert property (p_r_once)
    else $error("read response repeated");
endmodule

bind pmtb_top pmtb_assertions u_pmtb_assertions (
  .clk_sys_i, .rst_i, .s_axi_arvalid, .s_axi_arready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .count_o, .special_event_o
);

// ---- tb/pmtb_sync_model.sv ----
`timescale 1ns/1ps
module pmtb_sync_model (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] gap_i,
  input  wire logic       sync_output_i,
  output logic            sync_o,
  output logic [7:0]      seen_o
);
  logic [7:0] cnt_ff;
  logic       last_ff;
  // gap of zero parks the line low, no stray edges
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || gap_i == 8'h0) begin
      cnt_ff <= 8'h0;
      sync_o <= 1'b0;
    end else begin
      cnt_ff <= (cnt_ff == gap_i) ? 8'h0 : cnt_ff + 8'h1;
      sync_o <= (cnt_ff == gap_i);
    end
  end
  always_ff @(posedge clk_sys_i) begin
    last_ff <= sync_output_i;
    if (rst_i) seen_o <= 8'h0;
    else if (sync_output_i && !last_ff) seen_o <= seen_o + 8'h1;
  end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
  import pmtb_pkg::*;
;
  logic clk_sys_i, rst_i, ce_i, idle_mode_i, sync_input1_i, sync_input2_i;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid_unused_i, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] count_o;
  logic sync_output_o, special_event_o, irq_o;
  logic [7:0] gap, seen;
  logic sync_pin, sync_sel, sync_inv;
  int errors, cmp_count, cyc;

  pmtb_top u_pmtb_top (.*);
  pmtb_sync_model u_pmtb_sync_model (.clk_sys_i, .rst_i, .gap_i(gap),
    .sync_output_i(sync_output_o), .sync_o(sync_pin), .seen_o(seen));
  // unselected pin rests at the inactive level of the chosen polarity
  assign sync_input1_i = sync_sel ? sync_inv : (sync_pin ^ sync_inv);
  assign sync_input2_i = sync_sel ? (sync_pin ^ sync_inv) : sync_inv;

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // bready and rready stay high, so no release race
  task automatic wr(input logic [3:0] a, input logic [15:0] d,
                    input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk(32'(s_axi_bresp), 32'(er), "bresp");
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, m,
                    input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk(s_axi_rdata & m, e, "rdata");
    chk(32'(s_axi_rresp), 32'(er), "rresp");
  endtask
  task automatic tick_gap(output int n);
    logic [15:0] c;
    c = count_o;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (count_o === c && n < 300);
  endtask
  task automatic ev_gap(output int n);
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (special_event_o !== 1'b1 && n < 300);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rd(OFS_CONTROL, 32'h0, 32'hFFFF, RESP_OKAY);
    rd(OFS_DIVSEL, 32'h0, 32'hFFFF, RESP_OKAY);
    rd(OFS_PERIOD, 32'hFFF8, 32'hFFFFFFFF, RESP_OKAY);
    rd(4'h2, 32'h0, 32'h0, RESP_SLVERR);
    wr(4'h2, 16'h1234, RESP_SLVERR);
    wr(OFS_PERIOD, 16'h1234, RESP_OKAY);
    rd(OFS_PERIOD, 32'h1234, 32'hFFFFFFFF, RESP_OKAY);
    $display("reset test done");
  endtask
  task automatic t_div;
    int n;
    wr(OFS_PERIOD, 16'h0010, RESP_OKAY);
    for (int c = 0; c < 7; c++) begin
      wr(OFS_CONTROL, 16'h0000, RESP_OKAY);
      wr(OFS_DIVSEL, 16'(c), RESP_OKAY);
      rd(OFS_DIVSEL, 32'(c), 32'hFFFF, RESP_OKAY);
      wr(OFS_CONTROL, 16'h8000, RESP_OKAY);
      tick_gap(n);
      tick_gap(n);
      chk(32'(n), 32'(1 << c), "divide");
    end
    wr(OFS_CONTROL, 16'h0000, RESP_OKAY);
    wr(OFS_DIVSEL, 16'h0000, RESP_OKAY);
    wr(OFS_CONTROL, 16'h8000, RESP_OKAY);
    n = 0;
    while (count_o !== 16'h0010 && n < 100) begin
      @(posedge clk_sys_i);
      n++;
    end
    tick_gap(n);
    chk(32'(count_o), 32'h0, "wrap");
    wr(OFS_CONTROL, 16'h0000, RESP_OKAY);
    // stop takes two edges to settle: last step, then clear
    repeat (2) @(posedge clk_sys_i);
    tick_gap(n);
    tick_gap(n);
    chk(32'(n), 32'd300, "stop");
    $display("divider test done");
  endtask
  task automatic t_irq;
    // drain events left by earlier runs so the raise below is fresh
    rd(OFS_IRQ_ST, 32'h3, 32'h3, RESP_OKAY);
    wr(OFS_IRQ_ST, 16'h0100, RESP_OKAY);
    wr(OFS_CONTROL, 16'h8000, RESP_OKAY);
    repeat (40) @(posedge clk_sys_i);
    chk(32'(irq_o), 32'h1, "irq raised");
    wr(OFS_CONTROL, 16'h0000, RESP_OKAY);
    rd(OFS_IRQ_ST, 32'h101, 32'h301, RESP_OKAY);
    rd(OFS_IRQ_ST, 32'h100, 32'h303, RESP_OKAY);
    @(posedge clk_sys_i);
    chk(32'(irq_o), 32'h0, "irq cleared");
    wr(OFS_IRQ_ST, 16'h0000, RESP_OKAY);
    wr(OFS_CONTROL, 16'h8000, RESP_OKAY);
    repeat (40) @(posedge clk_sys_i);
    chk(32'(irq_o), 32'h0, "irq masked");
    wr(OFS_CONTROL, 16'h0000, RESP_OKAY);
    rd(OFS_IRQ_ST, 32'h1, 32'h1, RESP_OKAY);
    $display("interrupt test done");
  endtask
  task automatic t_sync(input logic s, input logic p);
    logic [15:0] mx;
    logic [15:0] v;
    logic [7:0]  s0;
    mx = 16'h0;
    v = 16'h0180 | {6'h0, p, 4'h0, s, 4'h0};
    @(posedge clk_sys_i);
    sync_sel <= s;
    sync_inv <= p;
    wr(OFS_PERIOD, 16'h0030, RESP_OKAY);
    wr(OFS_CONTROL, v, RESP_OKAY);
    chk(32'(sync_output_o), 32'(p), "sync idle");
    gap <= 8'h20;
    wr(OFS_CONTROL, v | 16'h8000, RESP_OKAY);
    s0 = seen;
    repeat (300) begin
      @(posedge clk_sys_i);
      if (count_o > mx) mx = count_o;
    end
    chk(32'(mx < 16'h0030), 32'h1, "sync restart");
    chk(32'(seen - s0 > 8'h3), 32'h1, "sync out");
    wr(OFS_CONTROL, 16'h0000, RESP_OKAY);
    gap <= 8'h0;
    sync_sel <= 1'b0;
    sync_inv <= 1'b0;
    $display("sync test done");
  endtask
  task automatic t_idle;
    int n;
    wr(OFS_CONTROL, 16'hA000, RESP_OKAY);
    idle_mode_i <= 1'b1;
    tick_gap(n);
    tick_gap(n);
    chk(32'(n), 32'd300, "idle halt");
    idle_mode_i <= 1'b0;
    tick_gap(n);
    tick_gap(n);
    chk(32'(n), 32'd1, "idle resume");
    $display("idle test done");
  endtask

  task automatic t_event;
    int n;
    wr(OFS_CONTROL, 16'h0802, RESP_OKAY);
    wr(OFS_CONTROL, 16'h8802, RESP_OKAY);
    ev_gap(n);
    ev_gap(n);
    // every third restart of a 17 cycle period
    chk(32'(n), 32'd51, "postscale");
    chk(32'(irq_o), 32'h1, "event irq");
    wr(OFS_CONTROL, 16'h1802, RESP_OKAY);
    rd(OFS_CONTROL, 32'h1802, 32'hFFFF, RESP_OKAY);
    wr(OFS_CONTROL, 16'h0000, RESP_OKAY);
    chk(32'(irq_o), 32'h0, "event irq off");
    $display("event test done");
  endtask
  task automatic t_freeze;
    int n;
    n = 0;
    while (count_o !== 16'h0005 && n < 100) begin
      @(posedge clk_sys_i);
      n++;
    end
    // the edge that saw 5 still steps to 6 before the freeze
    ce_i <= 1'b0;
    repeat (20) @(posedge clk_sys_i);
    chk(32'(count_o), 32'h6, "freeze");
    ce_i <= 1'b1;
    tick_gap(n);
    tick_gap(n);
    chk(32'(n), 32'd1, "thaw");
    $display("freeze test done");
  endtask

  task automatic test_done;
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk_sys_i);
      cyc++;
      if (cyc == 20000) begin
        errors++;
        $display("ERROR %0t timeout", $time);
        test_done;
      end
    end
  end
  initial begin
    {rst_i, ce_i, s_axi_bready, s_axi_rready} = 4'hF;
    {idle_mode_i, sync_sel, sync_inv, s_axi_awvalid, s_axi_wvalid} = 5'h0;
    {s_axi_arvalid, s_axi_rvalid_unused_i} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    gap = 8'h0;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_reset;
    t_div;
    t_irq;
    t_event;
    t_sync(1'b0, 1'b0);
    t_sync(1'b1, 1'b1);
    t_idle;
    t_freeze;
    test_done;
  end
endmodule
